// *** src/magnetometer_measurement_control.sv ***
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Single code measures once, then mode clears
// - Completion sets ready; survives later mode changes
// - Ready pin low exactly while ready flag set
// - Results hold old data during measurement
// - Six periodic codes at six repetition rates
// - Sleep between measurements, wake on interval
// - Rewriting periodic code restarts, clears nothing
// - Result or second status read clears flags
// - Results frozen from read start to status
// - Unread set overtaken sets skip, keeps ready
// - Set during protected read dropped, skip set
// - Overflow flag from axis magnitude sum limit
// - Self-test code measures once with source
// - Noise filter bit, changed only when idle
// - Drive select bit, changed only when idle
// - Buffer pushes sets, drops oldest when full
// - X read loads head, second status read pops
// - Buffer skip on full push, clear on pop
// - Empty read flags and forces invalid axes
// - Buffer ready follows count against watermark
// - Reset empties the buffer
module magnetometer_measurement_control #(
   parameter int unsigned OSC_HZ = 15625000,  // Interval oscillator rate
   parameter int          DEPTH  = 32         // Buffer depth in sets
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output      logic [31:0]        prdata,
   output      logic               pready,
   output      logic               pslverr,
   input  wire logic               osc_clk,
   input  wire logic signed [15:0] afe_x,
   input  wire logic signed [15:0] afe_y,
   input  wire logic signed [15:0] afe_z,
   output      logic               sensor_power,
   output      logic               self_test_source,
   output      logic               noise_filter_enable,
   output      logic               sensor_drive_select,
   output      logic               ready_pin_n_out,
   output      logic               ready_pin_n_oe_n
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions

   // True for the six periodic codes
   function automatic logic is_periodic(input logic [4:0] m);
      is_periodic = (m == magnetometer_pkg::MODE_P10) || (m == magnetometer_pkg::MODE_P20) ||
                    (m == magnetometer_pkg::MODE_P50) || (m == magnetometer_pkg::MODE_P100) ||
                    (m == magnetometer_pkg::MODE_P200) || (m == magnetometer_pkg::MODE_P1);
   endfunction

   // Magnitude of one axis
   function automatic logic [16:0] mag(input logic signed [15:0] v);
      mag = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
   endfunction

   // Overflow test on the sum of magnitudes
   function automatic logic ovf_of(input logic signed [15:0] x, input logic signed [15:0] y,
                                   input logic signed [15:0] z);
      ovf_of = ({2'b00, mag(x)} + {2'b00, mag(y)} + {2'b00, mag(z)}) >= 19'(magnetometer_pkg::OVF_LSB);
   endfunction

   // Noise filter: mean of new and previous sample
   function automatic logic signed [15:0] avg(input logic signed [15:0] a,
                                              input logic signed [15:0] b);
      logic signed [16:0] s;
      s   = 17'($signed(a)) + 17'($signed(b));
      avg = s[16:1];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State

   magnetometer_pkg::meas_state_t state_q, state_d;
   logic [4:0]                    mode_q, mode_d;          // Active mode code
   logic                          nsf_q, sdr_q, fifo_q;    // Option bits
   logic [4:0]                    wm_q;                    // Watermark level
   logic [15:0]                   meas_cnt_q;              // Conversion cycle count
   logic [31:0]                   ivl_q;                   // Oscillator ticks since start
   logic                          osc_s1_q, osc_s2_q, osc_s3_q;
   magnetometer_pkg::meas_set_t   res_q, res_d;            // Result registers
   logic                          data_ready_flag_q, data_ready_flag_d;          // Data ready flag
   logic                          skip_q, skip_d;          // Data skip flag
   logic                          prot_q, prot_d;          // Read protection
   logic                          inv_q, inv_d;            // Empty read flag
   magnetometer_pkg::meas_set_t   mem_q [DEPTH];           // Set buffer
   logic [AW-1:0]                 rdp_q, wrp_q;            // Buffer pointers
   logic [CW-1:0]                 cnt_q, cnt_d;            // Stored sets
   logic [31:0]                   prdata_q;
   logic                          pready_q, pslverr_q;
   logic                          power_q, self_q, pin_oe_n_q;

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode: no wait state, every access answers on the first access edge

   wire        setup   = psel & ~penable;
   wire        acc     = psel & penable & pready_q;
   wire        wr      = acc & pwrite;
   wire        rd      = acc & ~pwrite;
   wire        a_ctrl  = (paddr == magnetometer_pkg::OFF_CTRL);
   wire        a_x     = (paddr == magnetometer_pkg::OFF_X);
   wire        a_res   = a_x | (paddr == magnetometer_pkg::OFF_Y) | (paddr == magnetometer_pkg::OFF_Z);
   wire        a_st2   = (paddr == magnetometer_pkg::OFF_ST2);
   wire        mapped  = a_ctrl | a_res | a_st2 | (paddr == magnetometer_pkg::OFF_ST1) |
                         (paddr == magnetometer_pkg::OFF_COUNT);
   wire        wr_ctrl = wr & a_ctrl;
   wire        rd_x    = rd & a_x;
   wire        rd_res  = rd & a_res;
   wire        rd_st2  = rd & a_st2;
   wire [31:0] ctrl_rd = {11'h000, wm_q, 5'h00, fifo_q, sdr_q, nsf_q, 3'h0, mode_q};
   // Byte lanes merged over the present control word
   wire [31:0] bmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [31:0] ctrl_w  = (pwdata & bmask) | (ctrl_rd & ~bmask);
   wire [4:0]  new_mode = ctrl_w[magnetometer_pkg::MODE_LSB +: 5];
   wire        new_start = is_periodic(new_mode) || (new_mode == magnetometer_pkg::MODE_SINGLE) ||
                           (new_mode == magnetometer_pkg::MODE_SELF);

   ////////////////////////////////////////////////////////////////////////////////
   // Oscillator edge detection and interval

   wire        osc_tick = osc_s2_q & ~osc_s3_q;
   // Rate table in oscillator ticks
   // periodic rate decode
   wire [31:0] ivl_lim  = (mode_q == magnetometer_pkg::MODE_P10)  ? OSC_HZ / magnetometer_pkg::RATE_P10 :
                          (mode_q == magnetometer_pkg::MODE_P20)  ? OSC_HZ / magnetometer_pkg::RATE_P20 :
                          (mode_q == magnetometer_pkg::MODE_P50)  ? OSC_HZ / magnetometer_pkg::RATE_P50 :
                          (mode_q == magnetometer_pkg::MODE_P100) ? OSC_HZ / magnetometer_pkg::RATE_P100 :
                          (mode_q == magnetometer_pkg::MODE_P200) ? OSC_HZ / magnetometer_pkg::RATE_P200 :
                                                                    OSC_HZ / magnetometer_pkg::RATE_P1;
   wire        ivl_exp  = osc_tick && (ivl_q >= ivl_lim - 32'd1);
   wire        meas_done = (state_q == magnetometer_pkg::ST_MEAS) &&
                           (meas_cnt_q == 16'(magnetometer_pkg::MEAS_CYC - 1));
   logic       restart;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode sequencer
   always_comb begin
      state_d = state_q;
      mode_d  = mode_q;
      restart = 1'b0;
      case (state_q)
         magnetometer_pkg::ST_IDLE: ;
         magnetometer_pkg::ST_MEAS: if (meas_done) begin
            if (is_periodic(mode_q)) begin
               state_d = magnetometer_pkg::ST_SLEEP;
            end else begin
               state_d = magnetometer_pkg::ST_IDLE;
               mode_d  = magnetometer_pkg::MODE_OFF;
            end
         end
         magnetometer_pkg::ST_SLEEP: if (ivl_exp) begin
            state_d = magnetometer_pkg::ST_MEAS;
            restart = 1'b1;
         end
         default: state_d = magnetometer_pkg::ST_IDLE;
      endcase
      if (wr_ctrl) begin
         mode_d  = new_mode;
         state_d = new_start ? magnetometer_pkg::ST_MEAS : magnetometer_pkg::ST_IDLE;
         restart = new_start;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result, flag and buffer next state

   wire signed [15:0] nx = nsf_q ? avg(afe_x, res_q.x) : afe_x;
   wire signed [15:0] ny = nsf_q ? avg(afe_y, res_q.y) : afe_y;
   wire signed [15:0] nz = nsf_q ? avg(afe_z, res_q.z) : afe_z;
   wire magnetometer_pkg::meas_set_t new_set = '{x: nx, y: ny, z: nz, ovf: ovf_of(nx, ny, nz)};
   wire magnetometer_pkg::meas_set_t bad_set = '{x: magnetometer_pkg::AXIS_INVALID,
      y: magnetometer_pkg::AXIS_INVALID, z: magnetometer_pkg::AXIS_INVALID, ovf: res_q.ovf};
   wire magnetometer_pkg::meas_set_t head   = mem_q[rdp_q];
   wire        empty  = (cnt_q == '0);
   wire        full   = (cnt_q == FULL_CNT);
   wire        push   = meas_done & fifo_q;
   wire        pop    = rd_st2 & fifo_q & ~empty;
   wire        drop   = push & full & ~pop;
   wire        load   = rd_x & fifo_q;
   wire        store  = meas_done & ~fifo_q & ~prot_q;
   wire        rd_beg = (rd_res | rd_st2) & ~fifo_q;
   wire [CW-1:0] cnt_n = cnt_q + CW'(push) - CW'(pop) - CW'(drop);

   always_comb begin
      res_d  = res_q;
      data_ready_flag_d = data_ready_flag_q;
      skip_d = skip_q;
      prot_d = prot_q;
      inv_d  = inv_q;
      cnt_d  = cnt_n;
      if (fifo_q) begin
         if (load) begin
            res_d = empty ? bad_set : head;
         end
         if (load && empty) begin
            inv_d = 1'b1;
         end else if (push) begin
            inv_d = 1'b0;
         end
         if (pop) begin
            skip_d = 1'b0;
         end
         if (push && full) begin
            skip_d = 1'b1;
         end
         data_ready_flag_d = (cnt_n >= {1'b0, wm_q});
         prot_d = 1'b0;
      end else begin
         if (rd_beg) begin
            data_ready_flag_d = 1'b0;
            skip_d = 1'b0;
         end
         if (rd_res) begin
            prot_d = 1'b1;
         end
         if (rd_st2) begin
            prot_d = 1'b0;
         end
         if (meas_done && (prot_q || data_ready_flag_q)) begin
            skip_d = 1'b1;
         end
         if (store) begin
            res_d  = new_set;
            data_ready_flag_d = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control word; filter, drive and watermark follow only while idle, buffer enable on any write, set only with a periodic mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= magnetometer_pkg::ST_IDLE;
         mode_q  <= magnetometer_pkg::CTRL_RESET[4:0];
         nsf_q   <= 1'b0;
         sdr_q   <= 1'b0;
         fifo_q  <= 1'b0;
         wm_q    <= 5'h00;
      end else begin
         state_q <= state_d;
         mode_q  <= mode_d;
         if (wr_ctrl && (state_q == magnetometer_pkg::ST_IDLE)) begin
            nsf_q <= ctrl_w[magnetometer_pkg::NSF_BIT];
            sdr_q <= ctrl_w[magnetometer_pkg::SDR_BIT];
            wm_q  <= ctrl_w[magnetometer_pkg::WM_LSB +: 5];
         end
         if (wr_ctrl) begin
            fifo_q <= ctrl_w[magnetometer_pkg::FIFO_BIT] & is_periodic(new_mode);
         end
      end
   end

   // Counters and oscillator synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_cnt_q <= 16'h0000;
         ivl_q      <= 32'h0000_0000;
         osc_s1_q   <= 1'b0;
         osc_s2_q   <= 1'b0;
         osc_s3_q   <= 1'b0;
      end else begin
         osc_s1_q   <= osc_clk;
         osc_s2_q   <= osc_s1_q;
         osc_s3_q   <= osc_s2_q;
         meas_cnt_q <= (restart || state_q != magnetometer_pkg::ST_MEAS) ? 16'h0000
                                                                        : meas_cnt_q + 16'h0001;
         ivl_q      <= restart ? 32'h0000_0000 : (osc_tick ? ivl_q + 32'h0000_0001 : ivl_q);
      end
   end

   // Results, flags and buffer pointers
   // reset leaves no stored sets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_q  <= '0;
         data_ready_flag_q <= 1'b0;
         skip_q <= 1'b0;
         prot_q <= 1'b0;
         inv_q  <= 1'b0;
         cnt_q  <= '0;
         rdp_q  <= '0;
         wrp_q  <= '0;
      end else begin
         res_q  <= res_d;
         data_ready_flag_q <= data_ready_flag_d;
         skip_q <= skip_d;
         prot_q <= prot_d;
         inv_q  <= inv_d;
         cnt_q  <= cnt_d;
         rdp_q  <= rdp_q + AW'(pop) + AW'(drop);
         wrp_q  <= wrp_q + AW'(push);
      end
   end

   // Buffer storage carries no reset; the count says what is valid
   // push set
   always_ff @(posedge pclk) begin
      if (push) begin
         mem_q[wrp_q] <= new_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data mux; X shows the buffer head so the load and the data agree
   wire [15:0] x_view = !fifo_q ? res_q.x : (empty ? magnetometer_pkg::AXIS_INVALID : head.x);
   wire [31:0] rd_mux =
      a_ctrl ? ctrl_rd :
      (paddr == magnetometer_pkg::OFF_ST1) ? {30'h0, skip_q, data_ready_flag_q} :
      a_x ? {16'h0000, x_view} :
      (paddr == magnetometer_pkg::OFF_Y) ? {16'h0000, res_q.y} :
      (paddr == magnetometer_pkg::OFF_Z) ? {16'h0000, res_q.z} :
      a_st2 ? {30'h0, inv_q, res_q.ovf} :
      (paddr == magnetometer_pkg::OFF_COUNT) ? {{(32 - CW){1'b0}}, cnt_q} : 32'h0000_0000;

   // Bus answer and pin drivers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q   <= 32'h0000_0000;
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
         power_q    <= 1'b0;
         self_q     <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end else begin
         prdata_q   <= setup ? rd_mux : prdata_q;
         pready_q   <= setup;
         pslverr_q  <= setup & ~mapped;
         power_q    <= (state_d == magnetometer_pkg::ST_MEAS);
         self_q     <= (state_d == magnetometer_pkg::ST_MEAS) && (mode_d == magnetometer_pkg::MODE_SELF);
         pin_oe_n_q <= ~data_ready_flag_d;
      end
   end

   assign prdata              = prdata_q;
   assign pready              = pready_q;
   assign pslverr             = pslverr_q;
   assign sensor_power        = power_q;
   assign self_test_source    = self_q;
   assign noise_filter_enable = nsf_q;
   assign sensor_drive_select = sdr_q;
   assign ready_pin_n_out     = 1'b0;
   assign ready_pin_n_oe_n    = pin_oe_n_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence single_done_s;
      meas_done && !wr_ctrl && !is_periodic(mode_q);
   endsequence
   sequence back_idle_s;
      (state_q == magnetometer_pkg::ST_IDLE) && (mode_q == magnetometer_pkg::MODE_OFF);
   endsequence

   AST_SINGLE_ENDS: assert property (single_done_s |=> back_idle_s)
      else $error("single measurement did not return to idle");
   AST_READY_SET: assert property (store && !wr_ctrl |=> data_ready_flag_q)
      else $error("ready not set on completion");
   AST_PIN_TRACKS: assert property (pin_oe_n_q == !data_ready_flag_q)
      else $error("ready pin disagrees with flag");
   AST_HOLD_MEAS: assert property ((state_q == magnetometer_pkg::ST_MEAS) && !meas_done && !load
                                   |=> $stable(res_q))
      else $error("results changed during measurement");
   AST_WAKE: assert property ((state_q == magnetometer_pkg::ST_SLEEP) && ivl_exp && !wr_ctrl
                              |=> (state_q == magnetometer_pkg::ST_MEAS) && (meas_cnt_q == 16'h0000))
      else $error("no wake after interval");
   AST_READ_CLEARS: assert property (rd_beg && !meas_done |=> !data_ready_flag_q && !skip_q)
      else $error("read start did not clear flags");
   AST_PROTECT: assert property (prot_q && meas_done && !fifo_q && !load
                                 |=> $stable(res_q) && skip_q)
      else $error("protected set overwritten");
   AST_OVF: assert property (store |=> res_q.ovf == ovf_of(res_q.x, res_q.y, res_q.z))
      else $error("overflow flag wrong");
   AST_FULL_DROP: assert property (push && full && !pop |=> (cnt_q == FULL_CNT) && skip_q)
      else $error("full buffer push mishandled");
   AST_EMPTY_READ: assert property (load && empty
                                    |=> inv_q && (res_q.x == magnetometer_pkg::AXIS_INVALID))
      else $error("empty read not flagged");
   AST_WATERMARK: assert property (fifo_q && $past(fifo_q) |-> data_ready_flag_q == (cnt_q >= {1'b0, wm_q}))
      else $error("ready disagrees with watermark");

endmodule

`default_nettype wire

// *** src/magnetometer_pkg.sv ***
package magnetometer_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the APB window
   localparam logic [7:0] OFF_CTRL  = 8'h00;  // Mode, filter, drive, buffer, watermark
   localparam logic [7:0] OFF_ST1   = 8'h04;  // Data ready and data skip
   localparam logic [7:0] OFF_X     = 8'h08;  // X axis result
   localparam logic [7:0] OFF_Y     = 8'h0c;  // Y axis result
   localparam logic [7:0] OFF_Z     = 8'h10;  // Z axis result
   localparam logic [7:0] OFF_ST2   = 8'h14;  // Overflow and empty read
   localparam logic [7:0] OFF_COUNT = 8'h18;  // Stored set count

   ////////////////////////////////////////////////////////////////////////////////
   // Control word field positions
   localparam int MODE_LSB = 0;   // Mode code, five bits
   localparam int NSF_BIT  = 8;   // Noise filter enable
   localparam int SDR_BIT  = 9;   // Drive select
   localparam int FIFO_BIT = 10;  // Buffer enable
   localparam int WM_LSB   = 16;  // Watermark level, five bits
   localparam int ST_DATA_READY_FLAG  = 0;   // Status bit positions in both status words
   localparam int ST_SKIP  = 1;
   localparam int ST_OVF   = 0;
   localparam int ST_INV   = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode codes
   localparam logic [4:0] MODE_OFF    = 5'h00;
   localparam logic [4:0] MODE_SINGLE = 5'h01;
   localparam logic [4:0] MODE_P10    = 5'h02;
   localparam logic [4:0] MODE_P20    = 5'h04;
   localparam logic [4:0] MODE_P50    = 5'h06;
   localparam logic [4:0] MODE_P100   = 5'h08;
   localparam logic [4:0] MODE_P200   = 5'h0a;
   localparam logic [4:0] MODE_P1     = 5'h0c;
   localparam logic [4:0] MODE_SELF   = 5'h10;

   // Repetition rates in Hz
   localparam int RATE_P10  = 10;
   localparam int RATE_P20  = 20;
   localparam int RATE_P50  = 50;
   localparam int RATE_P100 = 100;
   localparam int RATE_P200 = 200;
   localparam int RATE_P1   = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing and values
   localparam int CLK_PERIOD_NS = 5;      // pclk period
   localparam int MEAS_NS       = 2000;   // Conversion time of one measurement
   localparam int MEAS_CYC      = (MEAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OVF_UT        = 4912;   // Overflow limit on |X|+|Y|+|Z|, in uT
   localparam int LSB_NT        = 150;    // Sensitivity, nT per count
   localparam int OVF_LSB       = (OVF_UT * 1000 + LSB_NT - 1) / LSB_NT;
   localparam logic [15:0] AXIS_INVALID = 16'h7fff;  // Forced on empty buffer read
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

   // One stored measurement set
   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
      logic               ovf;
   } meas_set_t;

   typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_SLEEP} meas_state_t;

endpackage

// *** testbench/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Host processor: APB master reading the block's registers
module host_model (
   input  wire logic        pclk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [7:0]  paddr,
   output var  logic [31:0] pwdata,
   output var  logic [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // Bus idle from time zero; full-word lanes only
   initial begin
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      pstrb = 4'hf;
   end
   // Setup, then access held until pready seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
endmodule
`default_nettype wire

// *** testbench/magnetometer_measurement_control_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module magnetometer_measurement_control_tb_top;
   logic pclk = 0, presetn = 0, osc_clk = 0, psel, penable, pwrite, pready, pslverr, erv;
   logic sp, sts, pin_out, pin_oe_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv, seed = 26550;
   logic [3:0] pstrb;
   logic signed [15:0] ax = 0, ay = 0, az = 0, px = 0;
   int bad_count = 0, check_count = 0, cyc = 0, i, c0;
   // Power-down time the host keeps before each new measurement mode after the first: 100 us at 5 ns
   localparam int IDLE_CYC = 20000;
   // Open-drain wire with pull-up
   wire ready_pin_n = pin_oe_n ? 1'b1 : pin_out;
   always #2.5 pclk = ~pclk;
   // Oscillator free-runs, phase unrelated to pclk
   always #32 osc_clk = ~osc_clk;
   magnetometer_measurement_control #(.OSC_HZ(16000)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk),
      .afe_x(ax), .afe_y(ay), .afe_z(az), .sensor_power(sp), .self_test_source(sts),
      .noise_filter_enable(), .sensor_drive_select(), .ready_pin_n_out(pin_out),
      .ready_pin_n_oe_n(pin_oe_n));
   host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      u_host.xfer(0, a, 0, rdv, erv);
   endtask
   task automatic wr(input logic [31:0] d);
      u_host.xfer(1, magnetometer_pkg::OFF_CTRL, d, rdv, erv);
   endtask
   // Bounded wait for the sensor power level
   task automatic wt(input logic v);
      for (int n = 0; n < 5000 && sp !== v; n++) @(posedge pclk);
   endtask
   task automatic done();
      wt(1);
      wt(0);
      repeat (2) @(posedge pclk);
   endtask
   // New random sensor words, small enough not to overflow
   task automatic sa();
      seed = xs();
      @(posedge pclk);
      px <= ax;
      ax <= $signed(seed[11:0]);
      ay <= $signed(seed[23:12]);
      az <= $signed(seed[31:24]);
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      rd(magnetometer_pkg::OFF_COUNT);
      chk(rdv, 0);
      for (i = 0; i < 2; i++) begin
         // idle pause after the single measurement's own power-down
         if (i) repeat (IDLE_CYC) @(posedge pclk);
         sa();
         wr(i ? magnetometer_pkg::MODE_SELF : magnetometer_pkg::MODE_SINGLE);
         // Large X and Y force overflow; driven after the write so each step assigns once
         if (i == 1) begin
            ax <= 16'sh7000;
            ay <= 16'sh1000;
         end
         wt(1);
         chk(sts, i);
         rd(magnetometer_pkg::OFF_X);
         chk(rdv, {16'h0000, px});
         rd(magnetometer_pkg::OFF_ST2);
         done();
         chk(ready_pin_n, 0);
         rd(magnetometer_pkg::OFF_ST1);
         chk(rdv, 1);
         rd(magnetometer_pkg::OFF_CTRL);
         chk(rdv, 0);
         rd(magnetometer_pkg::OFF_X);
         chk(rdv, {16'h0000, ax});
         // Self-test X far outside its window must be judged a failure
         if (i) chk($signed(rdv[15:0]) inside {[-200:200]}, 0);
         rd(magnetometer_pkg::OFF_ST1);
         chk(rdv, 0);
         rd(magnetometer_pkg::OFF_ST2);
         chk(rdv, i);
      end
      repeat (IDLE_CYC) @(posedge pclk);
      sa();
      wr(magnetometer_pkg::MODE_P200);
      wt(1);
      c0 = cyc;
      done();
      wt(1);
      chk((cyc - c0 > 1000) && (cyc - c0 < 1050), 1);
      done();
      rd(magnetometer_pkg::OFF_ST1);
      chk(rdv, 3);
      rd(magnetometer_pkg::OFF_X);
      sa();
      done();
      rd(magnetometer_pkg::OFF_ST1);
      chk(rdv, 2);
      rd(magnetometer_pkg::OFF_X);
      chk(rdv, {16'h0000, px});
      rd(magnetometer_pkg::OFF_ST2);
      done();
      rd(magnetometer_pkg::OFF_X);
      chk(rdv, {16'h0000, ax});
      rd(magnetometer_pkg::OFF_ST2);
      wr(magnetometer_pkg::MODE_P200);
      repeat (2) @(posedge pclk);
      chk(sp, 1);
      // idle pause before each new mode
      wr(0);
      repeat (IDLE_CYC) @(posedge pclk);
      wr(32'h0000_040a);
      rd(magnetometer_pkg::OFF_X);
      chk(rdv, {16'h0000, magnetometer_pkg::AXIS_INVALID});
      rd(magnetometer_pkg::OFF_ST2);
      chk(rdv[1], 1);
      done();
      rd(magnetometer_pkg::OFF_COUNT);
      chk(rdv, 1);
      // Head set loads on X access, second status read removes it
      rd(magnetometer_pkg::OFF_X);
      chk(rdv, {16'h0000, ax});
      rd(magnetometer_pkg::OFF_ST2);
      rd(magnetometer_pkg::OFF_COUNT);
      chk(rdv, 0);
      u_host.xfer(0, 8'h40, 0, rdv, erv);
      chk(erv, 1);
      print_verdict();
   end
endmodule
`default_nettype wire
